// ==== hw/pbc_pkg.sv ====
// constants for the phy basic control register block
package pbc_pkg;
   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [4:0] PBC_ADDR_CTRL = 5'h00;
   localparam int PBC_DW = 16;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int PBC_B_RESET = 15;
   localparam int PBC_B_LOOPBACK = 14;
   localparam int PBC_B_SPEED = 13;
   localparam int PBC_B_AN_EN = 12;
   localparam int PBC_B_PWR_DOWN = 11;
   localparam int PBC_B_AN_RESTART = 9;
   localparam int PBC_B_DUPLEX = 8;
   localparam int PBC_B_COL_TEST = 7;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic PBC_RST_SPEED = 1'b1;
   localparam logic PBC_RST_AN_EN = 1'b1;
   localparam logic PBC_RST_LOOPBACK = 1'b0;
   localparam logic PBC_RST_PWR_DOWN = 1'b0;
   localparam logic PBC_RST_DUPLEX = 1'b0;
   localparam logic PBC_RST_COL_TEST = 1'b0;
   localparam logic [15:0] PBC_ZERO16 = 16'h0000;

   // ****************************************************************
   // duplex capability of the phy
   // ****************************************************************
   typedef enum logic [1:0] {
      PBC_DUP_BOTH,
      PBC_DUP_FULL_ONLY,
      PBC_DUP_HALF_ONLY
   } pbc_dup_t;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int PBC_CLK_PERIOD_NS = 10;
   localparam int PBC_DEAD_TIME_NS = 560;
   // longest time, rounded down
   localparam int PBC_DEAD_CYCLES = PBC_DEAD_TIME_NS / PBC_CLK_PERIOD_NS;
   localparam int PBC_TMR_W = 8;
   // the cycle that starts the timer is already dead, so one less is loaded
   localparam logic [PBC_TMR_W-1:0] PBC_DEAD_LOAD = PBC_TMR_W'(PBC_DEAD_CYCLES - 1);
   localparam logic [PBC_TMR_W-1:0] PBC_RESET_LOAD_DEF = 8'h10;
endpackage

// ==== hw/pbc_timer.sv ====
// one-shot down counter used for reset hold and loopback dead time
`timescale 1ns/1ns
`default_nettype none
module pbc_timer
   import pbc_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // control
   input wire logic start,
   input wire logic [PBC_TMR_W-1:0] load,
   // status
   output logic busy
);
   typedef struct packed {
      logic [PBC_TMR_W-1:0] cnt;
   } pbc_tmr_st_t;

   pbc_tmr_st_t st_q;
   pbc_tmr_st_t st_d;

   // ****************************************************************
   // count down to zero; a new start reloads
   // ****************************************************************
   always_comb begin
      st_d = st_q;
      if (start) begin
         st_d.cnt = load;
      end else if (st_q.cnt != '0) begin
         st_d.cnt = st_q.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign busy = (st_q.cnt != '0);
endmodule // pbc_timer
`default_nettype wire

// ==== hw/pbc_ctrl.sv ====
// phy basic control register with loopback, collision test and management port
//
// Contract
// - writing one to bit 15 restores status and control defaults, then clears
// - bit 15 reads one during reset; writes only accepted after completion, reads answered throughout
// - bit 14 loops transmit nibbles into receive path, isolating network receiver
// - entering loopback yields up to 560 ns of invalid receive data
// - configuration loopback setting overrides the management loopback bit
// - bit 13 selects 100 or 10 Mbps only without autoneg; default one
// - bit 12 enables autoneg, default one; speed and duplex ignored then
// - bit 11 enters low power mode; clearing returns to normal
// - writing one to bit 9 restarts autoneg; bit clears itself
// - bit 8 selects full or half duplex without autoneg; default zero
// - single duplex capability forces bit 8 to that supported mode
// - in loopback the behaviour does not depend on the duplex bit
// - bit 7 forces collision whenever transmit enable is asserted
`timescale 1ns/1ns
`default_nettype none
module pbc_ctrl
   import pbc_pkg::*;
#(
   parameter pbc_dup_t DUP_SUPPORT = PBC_DUP_BOTH,
   parameter logic [PBC_TMR_W-1:0] RESET_LOAD = PBC_RESET_LOAD_DEF
)(
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // management register port
   input wire logic mgmt_req,
   input wire logic mgmt_we,
   input wire logic [4:0] mgmt_addr,
   input wire logic [PBC_DW-1:0] mgmt_wdata,
   output logic [PBC_DW-1:0] mgmt_rdata,
   output logic mgmt_ack,
   output logic mgmt_busy,
   // device configuration and autoneg result
   input wire logic cfg_loopback,
   input wire logic an_speed_100,
   input wire logic an_full_duplex,
   // mac transmit side
   input wire logic [3:0] txd,
   input wire logic tx_en,
   // network receive pins
   input wire logic [3:0] net_rxd,
   input wire logic net_rx_dv,
   input wire logic net_col,
   // mac receive side
   output logic [3:0] rxd,
   output logic rx_dv,
   output logic col,
   // phy control outputs
   output logic phy_soft_reset,
   output logic an_restart,
   output logic an_enable,
   output logic speed_100,
   output logic full_duplex,
   output logic power_down,
   output logic loopback_active,
   output logic rx_isolate
);
   typedef struct packed {
      logic speed;
      logic an_en;
      logic pwr_down;
      logic loopback;
      logic duplex;
      logic col_test;
      logic lb_prev;
      logic [5:0] sync1;
      logic [5:0] sync2;
      logic [3:0] rxd;
      logic rx_dv;
      logic col;
      logic [PBC_DW-1:0] rdata;
      logic ack;
      logic soft_rst;
      logic restart;
      logic spd_eff;
      logic dup_eff;
   } pbc_st_t;

   pbc_st_t st_q;
   pbc_st_t st_d;
   logic rst_busy;
   logic dead_busy;
   logic lb_eff;
   logic wr_ctrl;
   logic start_reset;
   logic start_dead;
   localparam int DEAD_MAX = PBC_DEAD_CYCLES;

   // ****************************************************************
   // helpers
   // ****************************************************************
   // duplex bit constrained by the phy's capability
   function automatic logic dup_fix(input logic v);
      unique case (DUP_SUPPORT)
         PBC_DUP_FULL_ONLY: dup_fix = 1'b1;
         PBC_DUP_HALF_ONLY: dup_fix = 1'b0;
         default: dup_fix = v;
      endcase
   endfunction

   // writes are refused while the soft reset holds the register
   assign wr_ctrl = mgmt_req && mgmt_we && !rst_busy && (mgmt_addr == PBC_ADDR_CTRL);
   assign start_reset = wr_ctrl && mgmt_wdata[PBC_B_RESET];
   // configuration loopback wins over the management bit
   assign lb_eff = cfg_loopback | st_q.loopback;
   assign start_dead = lb_eff && !st_q.lb_prev;

   // ****************************************************************
   // timers
   // ****************************************************************
   pbc_timer u_rst_tmr (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .start(start_reset),
      .load(RESET_LOAD),
      .busy(rst_busy)
   );

   pbc_timer u_dead_tmr (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .start(start_dead),
      .load(PBC_DEAD_LOAD),
      .busy(dead_busy)
   );

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      st_d = st_q;
      st_d.soft_rst = 1'b0;
      st_d.restart = 1'b0;
      st_d.ack = mgmt_req;
      st_d.lb_prev = lb_eff;
      // network pins pass two flip-flops before use
      st_d.sync1 = {net_col, net_rx_dv, net_rxd};
      st_d.sync2 = st_q.sync1;

      // register write; reserved bits are not stored
      if (start_reset) begin
         st_d.speed = PBC_RST_SPEED;
         st_d.an_en = PBC_RST_AN_EN;
         st_d.loopback = PBC_RST_LOOPBACK;
         st_d.pwr_down = PBC_RST_PWR_DOWN;
         st_d.duplex = dup_fix(PBC_RST_DUPLEX);
         st_d.col_test = PBC_RST_COL_TEST;
         st_d.soft_rst = 1'b1;
      end else if (wr_ctrl) begin
         st_d.loopback = mgmt_wdata[PBC_B_LOOPBACK];
         st_d.speed = mgmt_wdata[PBC_B_SPEED];
         st_d.an_en = mgmt_wdata[PBC_B_AN_EN];
         st_d.pwr_down = mgmt_wdata[PBC_B_PWR_DOWN];
         st_d.duplex = dup_fix(mgmt_wdata[PBC_B_DUPLEX]);
         st_d.col_test = mgmt_wdata[PBC_B_COL_TEST];
         st_d.restart = mgmt_wdata[PBC_B_AN_RESTART];
      end

      // read data; restart always reads zero since it launches at once
      st_d.rdata = PBC_ZERO16;
      if (mgmt_addr == PBC_ADDR_CTRL) begin
         st_d.rdata[PBC_B_RESET] = rst_busy | start_reset;
         st_d.rdata[PBC_B_LOOPBACK] = st_q.loopback;
         st_d.rdata[PBC_B_SPEED] = st_q.speed;
         st_d.rdata[PBC_B_AN_EN] = st_q.an_en;
         st_d.rdata[PBC_B_PWR_DOWN] = st_q.pwr_down;
         st_d.rdata[PBC_B_DUPLEX] = st_q.duplex;
         st_d.rdata[PBC_B_COL_TEST] = st_q.col_test;
      end
      if (!mgmt_req) begin
         st_d.rdata = st_q.rdata;
      end

      // effective link mode; autoneg result overrides manual bits
      st_d.spd_eff = st_q.an_en ? an_speed_100 : st_q.speed;
      st_d.dup_eff = st_q.an_en ? an_full_duplex : st_q.duplex;
      if (lb_eff) begin
         st_d.dup_eff = 1'b1;
      end

      // receive path: loopback of transmit nibbles or synchronised pins
      if (lb_eff) begin
         st_d.rxd = txd;
         st_d.rx_dv = tx_en && !dead_busy && !start_dead;
      end else begin
         st_d.rxd = st_q.sync2[3:0];
         st_d.rx_dv = st_q.sync2[4];
      end
      if (st_q.pwr_down) begin
         st_d.rx_dv = 1'b0;
      end

      // forced collision follows transmit enable; network col is isolated in loopback
      st_d.col = (st_q.col_test && tx_en) || (!lb_eff && st_q.sync2[5]);
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= '0;
         st_q.speed <= PBC_RST_SPEED;
         st_q.an_en <= PBC_RST_AN_EN;
         st_q.duplex <= (DUP_SUPPORT == PBC_DUP_FULL_ONLY);
         st_q.spd_eff <= PBC_RST_SPEED;
      end else begin
         st_q <= st_d;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign mgmt_rdata = st_q.rdata;
   assign mgmt_ack = st_q.ack;
   assign mgmt_busy = rst_busy;
   assign rxd = st_q.rxd;
   assign rx_dv = st_q.rx_dv;
   assign col = st_q.col;
   assign phy_soft_reset = st_q.soft_rst;
   assign an_restart = st_q.restart;
   assign an_enable = st_q.an_en;
   assign speed_100 = st_q.spd_eff;
   assign full_duplex = st_q.dup_eff;
   assign power_down = st_q.pwr_down;
   assign loopback_active = lb_eff;
   assign rx_isolate = lb_eff;

   // ****************************************************************
   // checks
   // ****************************************************************
   reset_read_one_a: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      mgmt_req && !mgmt_we && mgmt_addr == PBC_ADDR_CTRL && rst_busy
      |=> mgmt_rdata[PBC_B_RESET])
      else $error("reset bit read zero during reset");

   reset_defaults_a: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      start_reset |=> phy_soft_reset && an_enable && !power_down && !st_q.loopback
         && st_q.speed && !st_q.col_test)
      else $error("soft reset did not restore defaults");

   reset_ends_a: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      start_reset |-> ##[1:300] !rst_busy)
      else $error("soft reset never completed");

   write_blocked_a: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      rst_busy && mgmt_req && mgmt_we |=> $stable(st_q.an_en) && $stable(st_q.pwr_down))
      else $error("write accepted during reset");

   restart_pulse_a: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      an_restart |=> !an_restart)
      else $error("restart did not self clear");

   loop_data_a: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      lb_eff |=> rxd == $past(txd))
      else $error("loopback nibble mismatch");

   dead_time_a: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      start_dead |=> !rx_dv [*8])
      else $error("valid data inside dead time");

   dead_bound_a: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      start_dead |-> ##[1:DEAD_MAX] !dead_busy)
      else $error("dead time longer than allowed");

   cfg_priority_a: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      cfg_loopback && !st_q.loopback |-> loopback_active && rx_isolate
         ##1 rxd == $past(txd))
      else $error("configuration loopback not honoured");

   dup_cap_a: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      DUP_SUPPORT != PBC_DUP_BOTH |-> st_q.duplex == (DUP_SUPPORT == PBC_DUP_FULL_ONLY))
      else $error("duplex bit differs from supported mode");

   manual_speed_a: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      !st_q.an_en && $stable(st_q.an_en) |=> speed_100 == $past(st_q.speed))
      else $error("manual speed not applied");

   loop_duplex_a: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      lb_eff |=> full_duplex)
      else $error("duplex depends on bit in loopback");

   col_force_a: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      st_q.col_test && tx_en |=> col)
      else $error("collision test did not force col");
endmodule // pbc_ctrl
`default_nettype wire

// ==== bench/pbc_mgmt_model.sv ====
// management master model driving the control register port
`timescale 1ns/1ns
`default_nettype none
module pbc_mgmt_model
   import pbc_pkg::*;
(
   // clock
   input wire logic clk_sys,
   // request side
   output logic mgmt_req,
   output logic mgmt_we,
   output logic [4:0] mgmt_addr,
   output logic [PBC_DW-1:0] mgmt_wdata,
   // answer side
   input wire logic [PBC_DW-1:0] mgmt_rdata,
   input wire logic mgmt_ack,
   input wire logic mgmt_busy
);
   // ****************************************************************
   // idle levels
   // ****************************************************************
   initial begin
      mgmt_req = 1'b0;
      mgmt_we = 1'b0;
      mgmt_addr = 5'h1f;
      mgmt_wdata = 16'ha5a5;
   end

   // ****************************************************************
   // one transaction, entered just after a rising edge
   // ****************************************************************
   task automatic xfer(input logic we, input logic [4:0] addr, input logic [15:0] data,
                       input bit wait_idle, output logic [15:0] rd, output logic acked);
      int n;
      n = 0;
      // a polite master holds off while the phy is still resetting
      while (wait_idle && mgmt_busy !== 1'b0 && n < 1000) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      mgmt_req = 1'b1;
      mgmt_we = we;
      mgmt_addr = addr;
      mgmt_wdata = data & 16'hfb80;
      @(posedge clk_sys);
      #1;
      // released address and data lines never keep the last value, so stale data cannot pass
      mgmt_req = 1'b0;
      mgmt_wdata = ~mgmt_wdata;
      mgmt_addr = ~mgmt_addr;
      @(posedge clk_sys);
      rd = mgmt_rdata;
      acked = mgmt_ack;
      #1;
   endtask
endmodule // pbc_mgmt_model
`default_nettype wire

// ==== bench/pbc_ctrl_tb.sv ====
// self-checking bench for the phy basic control register
`timescale 1ns/1ns
`default_nettype none
module pbc_ctrl_tb;
   import pbc_pkg::*;
   localparam logic [7:0] RL = 8'h08;
   logic clk_sys, arst_n, mgmt_req, mgmt_we, mgmt_ack, mgmt_busy;
   logic [4:0] mgmt_addr;
   logic [15:0] mgmt_wdata, mgmt_rdata, rd, w, rd_fo;
   logic cfg_loopback, an_speed_100, an_full_duplex, tx_en, net_rx_dv, net_col;
   logic [3:0] txd, net_rxd, rxd, pt;
   logic rx_dv, col, phy_soft_reset, an_restart, an_enable, speed_100, full_duplex;
   logic power_down, loopback_active, rx_isolate, ak, pe, fd_fo;
   int bad_count, num_checks, n_rst, n_sr, n_busy, exp_rst, n;

   pbc_ctrl #(.DUP_SUPPORT(PBC_DUP_BOTH), .RESET_LOAD(RL)) dut_u (.clk_sys(clk_sys),
      .arst_n(arst_n), .mgmt_req(mgmt_req), .mgmt_we(mgmt_we), .mgmt_addr(mgmt_addr),
      .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_ack(mgmt_ack),
      .mgmt_busy(mgmt_busy), .cfg_loopback(cfg_loopback), .an_speed_100(an_speed_100),
      .an_full_duplex(an_full_duplex), .txd(txd), .tx_en(tx_en), .net_rxd(net_rxd),
      .net_rx_dv(net_rx_dv), .net_col(net_col), .rxd(rxd), .rx_dv(rx_dv), .col(col),
      .phy_soft_reset(phy_soft_reset), .an_restart(an_restart), .an_enable(an_enable),
      .speed_100(speed_100), .full_duplex(full_duplex), .power_down(power_down),
      .loopback_active(loopback_active), .rx_isolate(rx_isolate));
   pbc_mgmt_model mst_u (.clk_sys(clk_sys), .mgmt_req(mgmt_req), .mgmt_we(mgmt_we),
      .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
      .mgmt_ack(mgmt_ack), .mgmt_busy(mgmt_busy));
   // second unit that only supports full duplex, sharing the management bus
   pbc_ctrl #(.DUP_SUPPORT(PBC_DUP_FULL_ONLY), .RESET_LOAD(RL)) dup_u (.clk_sys(clk_sys),
      .arst_n(arst_n), .mgmt_req(mgmt_req), .mgmt_we(mgmt_we), .mgmt_addr(mgmt_addr),
      .mgmt_wdata(mgmt_wdata), .mgmt_rdata(rd_fo), .mgmt_ack(), .mgmt_busy(),
      .cfg_loopback(cfg_loopback), .an_speed_100(an_speed_100),
      .an_full_duplex(an_full_duplex), .txd(txd), .tx_en(tx_en), .net_rxd(net_rxd),
      .net_rx_dv(net_rx_dv), .net_col(net_col), .rxd(), .rx_dv(), .col(),
      .phy_soft_reset(), .an_restart(), .an_enable(), .speed_100(),
      .full_duplex(fd_fo), .power_down(), .loopback_active(), .rx_isolate());

   // ****************************************************************
   // clock and pulse monitors
   // ****************************************************************
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // pulses stand one cycle, so they are counted rather than caught by a task
   always @(posedge clk_sys) begin
      n_rst += (an_restart === 1'b1);
      n_sr += (phy_soft_reset === 1'b1);
      n_busy += (mgmt_busy === 1'b1);
   end

   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [15:0] d);
      mst_u.xfer(1'b1, PBC_ADDR_CTRL, d, 1'b1, rd, ak);
   endtask
   task automatic rdr(input logic [4:0] a);
      mst_u.xfer(1'b0, a, 16'h0000, 1'b1, rd, ak);
   endtask
   // readable bits of the register for a given written word
   function automatic logic [15:0] exp_rd(input logic [15:0] d);
      return d & 16'h7980;
   endfunction
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // watchdog: the tests need well under 30000 cycles
   initial begin
      #300000;
      bad_count++;
      complete_run();
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      {arst_n, cfg_loopback, an_speed_100, an_full_duplex, tx_en, net_rx_dv, net_col} = 7'h00;
      {txd, net_rxd} = 8'h00;
      {bad_count, num_checks, n_rst, n_sr, n_busy, exp_rst} = '0;
      void'($urandom(32'h8a87));
      cyc(5);
      arst_n = 1'b1;
      rdr(PBC_ADDR_CTRL);
      check("reset_value", rd, 16'h3000);
      check("fo_reset_value", rd_fo, 16'h3100);
      check("ack", ak, 1'b1);
      // autoneg is on after reset, so the link mode follows its result
      check("out_an", {speed_100, full_duplex}, {an_speed_100, an_full_duplex});
      check("out_defaults", {an_enable, power_down}, 2'b10);
      wr(16'h0000);
      mst_u.xfer(1'b1, 5'h05, 16'hffff, 1'b1, rd, ak);
      rdr(5'h05);
      check("unmapped", rd, 16'h0000);
      rdr(PBC_ADDR_CTRL);
      check("unmapped_write", rd, 16'h0000);
      $display("test defaults done");
      // random field writes with all-ones and all-zeros corners
      for (int i = 0; i < 16; i++) begin
         w = (i == 0) ? 16'h3fff : (i == 1) ? 16'h0000 : 16'($urandom) & 16'h3b80;
         {an_speed_100, an_full_duplex} = 2'($urandom);
         exp_rst += w[9];
         wr(w);
         rdr(PBC_ADDR_CTRL);
         check("ctrl_read", rd, exp_rd(w));
         check("an_enable", an_enable, w[12]);
         check("speed_100", speed_100, w[12] ? an_speed_100 : w[13]);
         check("full_duplex", full_duplex, w[12] ? an_full_duplex : w[8]);
         check("power_down", power_down, w[11]);
         check("fo_ctrl_read", rd_fo, exp_rd(w) | 16'h0100);
         check("fo_full_duplex", fd_fo, w[12] ? an_full_duplex : 1'b1);
         check("col_off", col, 1'b0);
      end
      check("restart_pulses", n_rst, exp_rst);
      $display("test fields done");
      // soft reset, with a read and a stray write while it runs
      wr(16'h0980);
      n_busy = 0;
      wr(16'h8000);
      mst_u.xfer(1'b0, PBC_ADDR_CTRL, 16'h0000, 1'b0, rd, ak);
      check("reset_busy_read", rd[15], 1'b1);
      mst_u.xfer(1'b1, PBC_ADDR_CTRL, 16'h0900, 1'b0, rd, ak);
      rdr(PBC_ADDR_CTRL);
      check("reset_restores", rd, 16'h3000);
      check("fo_reset_restores", rd_fo, 16'h3100);
      check("busy_cycles", n_busy, RL);
      check("status_reset_pulse", n_sr, 1);
      $display("test soft reset done");
      // loopback: dead time, echo, isolation, duplex ignored
      tx_en = 1'b1;
      net_col = 1'b1;
      wr(16'h4000);
      check("lb_duplex", full_duplex, 1'b1);
      check("lb_isolate", {loopback_active, rx_isolate}, 2'b11);
      n = 0;
      while (rx_dv !== 1'b1 && n < 80) begin
         cyc(1);
         n++;
      end
      check("dead_time", n <= PBC_DEAD_CYCLES, 1'b1);
      for (int i = 0; i < 24; i++) begin
         if (i == 12)
            wr(16'h4180);
         {txd, tx_en, net_rxd, net_rx_dv} = 10'($urandom);
         pt = txd;
         pe = tx_en;
         cyc(1);
         check("lb_rxd", rxd, pt);
         check("lb_rx_dv", rx_dv, pe);
         check("col_test", col, pe & (i >= 12));
      end
      $display("test loopback done");
      // configuration loopback wins over the register bit
      wr(16'h0000);
      cfg_loopback = 1'b1;
      cyc(1);
      check("cfg_loopback", {loopback_active, rx_isolate}, 2'b11);
      cfg_loopback = 1'b0;
      {tx_en, net_col, net_rx_dv, net_rxd} = 7'b0011010;
      cyc(5);
      check("net_path", {loopback_active, rx_dv, rxd}, 6'b011010);
      wr(16'h0800);
      cyc(2);
      check("pd_rx", {power_down, rx_dv}, 2'b10);
      wr(16'h0000);
      check("pd_exit", power_down, 1'b0);
      $display("test config and power done");
      complete_run();
   end
endmodule // pbc_ctrl_tb
`default_nettype wire
